/* File: logic/vr_reg_pkg.sv */
// Purpose: constants and types for the regulator serial register bank
// Assumes: 8-bit register indices, 4-bit domain codes on the link
// Notes: link frame is start bit, domain, write flag, index, then data
package vr_reg_pkg;

    // ************************************************************
    // domains
    // ************************************************************
    localparam logic [3:0] RAIL_DOM_LAST = 4'h3;
    localparam logic [3:0] SYS_POWER_DOM = 4'hd;

    // ************************************************************
    // register indices
    // ************************************************************
    localparam logic [7:0] IDX_VENDOR_CODE = 8'h00;
    localparam logic [7:0] IDX_PRODUCT_CODE = 8'h01;
    localparam logic [7:0] IDX_SILICON_REVISION = 8'h02;
    localparam logic [7:0] IDX_MANUFACTURE_DATE = 8'h03;
    localparam logic [7:0] IDX_PROTOCOL_VERSION = 8'h05;
    localparam logic [7:0] IDX_FEATURE_BITMAP = 8'h06;
    localparam logic [7:0] IDX_PRIMARY_STATUS = 8'h10;
    localparam logic [7:0] IDX_SECONDARY_STATUS = 8'h11;
    localparam logic [7:0] IDX_THERMAL_ZONE = 8'h12;
    localparam logic [7:0] IDX_OUTPUT_CURRENT = 8'h15;
    localparam logic [7:0] IDX_REG_TEMPERATURE = 8'h17;
    localparam logic [7:0] IDX_SUPPLY_VOLTAGE = 8'h1a;
    localparam logic [7:0] IDX_SUPPLY_POWER = 8'h1b;
    localparam logic [7:0] IDX_STATUS_SNAPSHOT = 8'h1c;
    localparam logic [7:0] IDX_CURRENT_LIMIT = 8'h21;
    localparam logic [7:0] IDX_POWER_SCALING = 8'h2e;

    // ************************************************************
    // fixed values and reset values
    // ************************************************************
    localparam logic [7:0] PROTOCOL_VERSION_VAL = 8'h05;
    localparam logic [7:0] FEATURE_BITMAP_VAL = 8'hd1;
    localparam logic [7:0] POWER_SCALING_VAL = 8'hff;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] THERMAL_ZONE_RST = 8'h00;
    localparam logic [7:0] SNAPSHOT_RST = 8'h00;
    localparam logic [7:0] CURRENT_LIMIT_RST = 8'h00;
    localparam logic [7:0] READING_RST = 8'h00;

    // ************************************************************
    // link frame counts
    // ************************************************************
    localparam logic [3:0] HDR_BITS = 4'hd;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam int HDR_WR_POS = 8;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_HDR,
        LS_WDATA,
        LS_WAIT,
        LS_SEND
    } link_state_t;

endpackage

/* File: logic/vr_serial_register_map.sv */
// Purpose: read-only register bank of a multi-rail regulator behind a serial link
// Assumes: readings and status come from logic on i_clk; link bits are sampled
//          on the rising edge of the master-driven link clock
// Notes: read answer is a low start bit then eight data bits, msb first
`timescale 1ns/1ps

// Behaviour
// - the system power domain answers only its reduced index set and no other.
// - index 00 returns the fixed vendor code in rail domains 0 to 3 and the system power domain.
// - index 01 returns the product code and index 02 the silicon revision.
// - the feature bitmap reads d1 with bits 0, 4, 6 and 7 set.
// - the primary status register resets to zero and is read after attention.
// - the secondary status register is read-only and resets to zero.
// - a read of secondary status copies the value read into the snapshot.
// - the output current reading is the unsigned converter code, ff at full scale.
// - the regulator temperature reads in whole degrees, 100 degrees as 64.
// - the supply voltage reading is the code 255 times volts over 28.
// - the current limit register is loaded once after power-up and then holds.
// - the thermal zone register resets to zero and is absent in system power.
// - the supply power register is readable, also in the system power domain.
// - the open-drain attention line is driven when status should be read.
// - the master clocks the link and the data line turns around for replies.
module vr_serial_register_map #(
    // arbitrary identity values
    parameter logic [7:0] VENDOR_CODE = 8'h5a,
    parameter logic [7:0] PRODUCT_CODE = 8'h3c,
    parameter logic [7:0] SILICON_REVISION = 8'h01,
    parameter logic [7:0] MANUFACTURE_DATE = 8'h00
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_link_clk,
    input wire logic i_sdio,
    output logic o_sdio_o,
    output logic o_sdio_oe,
    output logic o_alert_o,
    output logic o_alert_oe,
    input wire logic [7:0] i_primary_status,
    input wire logic [7:0] i_secondary_status,
    input wire logic [7:0] i_thermal_zone,
    input wire logic [7:0] i_output_current_code,
    input wire logic [7:0] i_temperature_code,
    input wire logic [7:0] i_supply_sense_code,
    input wire logic [7:0] i_supply_power_code,
    input wire logic [7:0] i_current_limit_program_pin_code
);

    // ************************************************************
    // state types
    // ************************************************************
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_tgl;
        logic rd_valid;
        logic [7:0] rd_data;
        logic [7:0] primary;
        logic [7:0] secondary;
        logic [7:0] thermal;
        logic [7:0] iout;
        logic [7:0] temp;
        logic [7:0] vin;
        logic [7:0] pin;
        logic [7:0] snapshot;
        logic [7:0] limit;
        logic limit_loaded;
        logic alert;
        logic alert_lvl;
    } core_t;

    typedef struct packed {
        logic ce_s1;
        logic ce_s2;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic req_tgl;
        vr_reg_pkg::link_state_t state;
        logic [3:0] cnt;
        logic [12:0] hdr;
        logic [7:0] shift;
        logic sdio_o;
        logic sdio_oe;
    } link_t;

    core_t core_ff;
    core_t nxt_core;
    link_t link_ff;
    link_t nxt_link;
    logic serve;
    logic hit;
    logic [7:0] hit_data;
    logic [3:0] req_dom;
    logic [7:0] req_idx;

    assign req_dom = link_ff.hdr[12:9];
    assign req_idx = link_ff.hdr[7:0];

    // ************************************************************
    // register lookup
    // ************************************************************
    always_comb begin
        hit = 1'b0;
        hit_data = 8'h00;
        if (req_dom <= vr_reg_pkg::RAIL_DOM_LAST) begin
            hit = 1'b1;
            case (req_idx)
                vr_reg_pkg::IDX_VENDOR_CODE: hit_data = VENDOR_CODE;
                vr_reg_pkg::IDX_PRODUCT_CODE: hit_data = PRODUCT_CODE;
                vr_reg_pkg::IDX_SILICON_REVISION: hit_data = SILICON_REVISION;
                vr_reg_pkg::IDX_MANUFACTURE_DATE: hit_data = MANUFACTURE_DATE;
                vr_reg_pkg::IDX_PROTOCOL_VERSION: hit_data = vr_reg_pkg::PROTOCOL_VERSION_VAL;
                vr_reg_pkg::IDX_FEATURE_BITMAP: hit_data = vr_reg_pkg::FEATURE_BITMAP_VAL;
                vr_reg_pkg::IDX_PRIMARY_STATUS: hit_data = core_ff.primary;
                vr_reg_pkg::IDX_SECONDARY_STATUS: hit_data = core_ff.secondary;
                vr_reg_pkg::IDX_THERMAL_ZONE: hit_data = core_ff.thermal;
                vr_reg_pkg::IDX_OUTPUT_CURRENT: hit_data = core_ff.iout;
                vr_reg_pkg::IDX_REG_TEMPERATURE: hit_data = core_ff.temp;
                vr_reg_pkg::IDX_SUPPLY_VOLTAGE: hit_data = core_ff.vin;
                vr_reg_pkg::IDX_SUPPLY_POWER: hit_data = core_ff.pin;
                vr_reg_pkg::IDX_STATUS_SNAPSHOT: hit_data = core_ff.snapshot;
                vr_reg_pkg::IDX_CURRENT_LIMIT: hit_data = core_ff.limit;
                default: hit = 1'b0;
            endcase
        end else if (req_dom == vr_reg_pkg::SYS_POWER_DOM) begin
            hit = 1'b1;
            case (req_idx)
                vr_reg_pkg::IDX_VENDOR_CODE: hit_data = VENDOR_CODE;
                vr_reg_pkg::IDX_PRODUCT_CODE: hit_data = PRODUCT_CODE;
                vr_reg_pkg::IDX_SILICON_REVISION: hit_data = SILICON_REVISION;
                vr_reg_pkg::IDX_MANUFACTURE_DATE: hit_data = MANUFACTURE_DATE;
                vr_reg_pkg::IDX_PROTOCOL_VERSION: hit_data = vr_reg_pkg::PROTOCOL_VERSION_VAL;
                vr_reg_pkg::IDX_PRIMARY_STATUS: hit_data = core_ff.primary;
                vr_reg_pkg::IDX_SECONDARY_STATUS: hit_data = core_ff.secondary;
                vr_reg_pkg::IDX_SUPPLY_POWER: hit_data = core_ff.pin;
                vr_reg_pkg::IDX_STATUS_SNAPSHOT: hit_data = core_ff.snapshot;
                vr_reg_pkg::IDX_POWER_SCALING: hit_data = vr_reg_pkg::POWER_SCALING_VAL;
                default: hit = 1'b0;
            endcase
        end
    end

    // ************************************************************
    // core domain
    // ************************************************************
    always_comb begin
        nxt_core = core_ff;
        serve = 1'b0;
        if (i_ce) begin
            nxt_core.req_s1 = link_ff.req_tgl;
            nxt_core.req_s2 = core_ff.req_s1;
            nxt_core.primary = i_primary_status;
            nxt_core.secondary = i_secondary_status;
            nxt_core.thermal = i_thermal_zone;
            nxt_core.iout = i_output_current_code;
            nxt_core.temp = i_temperature_code;
            nxt_core.vin = i_supply_sense_code;
            nxt_core.pin = i_supply_power_code;
            if (!core_ff.limit_loaded) begin
                nxt_core.limit = i_current_limit_program_pin_code;
                nxt_core.limit_loaded = 1'b1;
            end
            if (core_ff.req_s2 != core_ff.req_seen) begin
                serve = 1'b1;
                nxt_core.req_seen = core_ff.req_s2;
                nxt_core.rd_valid = hit;
                nxt_core.rd_data = hit_data;
                nxt_core.ack_tgl = ~core_ff.ack_tgl;
                if (hit && req_idx == vr_reg_pkg::IDX_SECONDARY_STATUS) begin
                    nxt_core.snapshot = hit_data;
                end
                if (hit && req_idx == vr_reg_pkg::IDX_PRIMARY_STATUS) begin
                    nxt_core.alert = 1'b0;
                end
            end
            // new nonzero status raises attention, set wins
            if (i_primary_status != core_ff.primary && i_primary_status != 8'h00) begin
                nxt_core.alert = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            core_ff <= '{
                primary: vr_reg_pkg::STATUS_RST,
                secondary: vr_reg_pkg::STATUS_RST,
                thermal: vr_reg_pkg::THERMAL_ZONE_RST,
                iout: vr_reg_pkg::READING_RST,
                temp: vr_reg_pkg::READING_RST,
                vin: vr_reg_pkg::READING_RST,
                pin: vr_reg_pkg::READING_RST,
                snapshot: vr_reg_pkg::SNAPSHOT_RST,
                limit: vr_reg_pkg::CURRENT_LIMIT_RST,
                rd_data: 8'h00,
                default: 1'b0
            };
        end else begin
            core_ff <= nxt_core;
        end
    end

    // ************************************************************
    // link domain
    // ************************************************************
    always_comb begin
        nxt_link = link_ff;
        nxt_link.ce_s1 = i_ce;
        nxt_link.ce_s2 = link_ff.ce_s1;
        if (link_ff.ce_s2) begin
            nxt_link.ack_s1 = core_ff.ack_tgl;
            nxt_link.ack_s2 = link_ff.ack_s1;
            case (link_ff.state)
                vr_reg_pkg::LS_IDLE: begin
                    nxt_link.sdio_oe = 1'b0;
                    if (!i_sdio) begin
                        nxt_link.state = vr_reg_pkg::LS_HDR;
                        nxt_link.cnt = 4'h0;
                    end
                end
                vr_reg_pkg::LS_HDR: begin
                    nxt_link.hdr = {link_ff.hdr[11:0], i_sdio};
                    nxt_link.cnt = link_ff.cnt + 4'h1;
                    if (link_ff.cnt == vr_reg_pkg::HDR_BITS - 4'h1) begin
                        nxt_link.cnt = 4'h0;
                        if (link_ff.hdr[vr_reg_pkg::HDR_WR_POS - 1]) begin
                            nxt_link.state = vr_reg_pkg::LS_WDATA;
                        end else begin
                            nxt_link.state = vr_reg_pkg::LS_WAIT;
                            nxt_link.req_tgl = ~link_ff.req_tgl;
                        end
                    end
                end
                vr_reg_pkg::LS_WDATA: begin
                    nxt_link.cnt = link_ff.cnt + 4'h1;
                    if (link_ff.cnt == vr_reg_pkg::DATA_BITS - 4'h1) begin
                        nxt_link.state = vr_reg_pkg::LS_IDLE;
                    end
                end
                vr_reg_pkg::LS_WAIT: begin
                    if (link_ff.ack_s2 != link_ff.ack_seen) begin
                        nxt_link.ack_seen = link_ff.ack_s2;
                        if (core_ff.rd_valid) begin
                            nxt_link.shift = core_ff.rd_data;
                            nxt_link.sdio_o = 1'b0;
                            nxt_link.sdio_oe = 1'b1;
                            nxt_link.cnt = 4'h0;
                            nxt_link.state = vr_reg_pkg::LS_SEND;
                        end else begin
                            nxt_link.state = vr_reg_pkg::LS_IDLE;
                        end
                    end
                end
                vr_reg_pkg::LS_SEND: begin
                    nxt_link.sdio_o = link_ff.shift[7];
                    nxt_link.shift = {link_ff.shift[6:0], 1'b0};
                    nxt_link.cnt = link_ff.cnt + 4'h1;
                    if (link_ff.cnt == vr_reg_pkg::DATA_BITS) begin
                        nxt_link.sdio_oe = 1'b0;
                        nxt_link.sdio_o = 1'b1;
                        nxt_link.state = vr_reg_pkg::LS_IDLE;
                    end
                end
                default: nxt_link.state = vr_reg_pkg::LS_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            link_ff <= '{
                state: vr_reg_pkg::LS_IDLE,
                cnt: 4'h0,
                hdr: 13'h0000,
                shift: 8'h00,
                sdio_o: 1'b1,
                default: 1'b0
            };
        end else begin
            link_ff <= nxt_link;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_sdio_o = link_ff.sdio_o;
    assign o_sdio_oe = link_ff.sdio_oe;
    assign o_alert_o = core_ff.alert_lvl;
    assign o_alert_oe = core_ff.alert;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_start_bit;
        $rose(link_ff.sdio_oe) && !link_ff.sdio_o;
    endsequence

    sequence s_data_then_release;
        link_ff.sdio_oe [*8] ##1 !link_ff.sdio_oe;
    endsequence

    a_vendor_read: assert property (@(posedge i_clk) disable iff (!i_arst_n || !i_ce)
        serve && hit && req_idx == vr_reg_pkg::IDX_VENDOR_CODE
        |=> core_ff.rd_valid && core_ff.rd_data == VENDOR_CODE)
        else $error("vendor code read wrong");

    a_revision_read: assert property (@(posedge i_clk) disable iff (!i_arst_n || !i_ce)
        serve && hit && req_idx == vr_reg_pkg::IDX_SILICON_REVISION
        |=> core_ff.rd_data == SILICON_REVISION)
        else $error("revision code read wrong");

    a_bitmap_read: assert property (@(posedge i_clk) disable iff (!i_arst_n || !i_ce)
        serve && req_dom == 4'h0 && req_idx == vr_reg_pkg::IDX_FEATURE_BITMAP
        |=> core_ff.rd_valid && core_ff.rd_data == 8'hd1)
        else $error("feature bitmap wrong");

    a_sys_reduced: assert property (@(posedge i_clk) disable iff (!i_arst_n || !i_ce)
        serve && req_dom == vr_reg_pkg::SYS_POWER_DOM
        && req_idx == vr_reg_pkg::IDX_THERMAL_ZONE |=> !core_ff.rd_valid)
        else $error("absent index answered in system domain");

    a_snapshot_copy: assert property (@(posedge i_clk) disable iff (!i_arst_n || !i_ce)
        serve && hit && req_idx == vr_reg_pkg::IDX_SECONDARY_STATUS
        |=> core_ff.snapshot == $past(core_ff.secondary))
        else $error("snapshot not copied");

    a_temp_read: assert property (@(posedge i_clk) disable iff (!i_arst_n || !i_ce)
        serve && hit && req_idx == vr_reg_pkg::IDX_REG_TEMPERATURE
        |=> core_ff.rd_data == $past(i_temperature_code, 2))
        else $error("temperature reading wrong");

    a_limit_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        core_ff.limit_loaded |=> $stable(core_ff.limit))
        else $error("current limit changed after load");

    a_alert_raise: assert property (@(posedge i_clk) disable iff (!i_arst_n || !i_ce)
        i_primary_status != core_ff.primary && i_primary_status != 8'h00
        |=> o_alert_oe && !o_alert_o)
        else $error("attention not driven");

    a_reply_frame: assert property (@(posedge i_link_clk)
        disable iff (!i_arst_n || !link_ff.ce_s2)
        s_start_bit |=> s_data_then_release)
        else $error("reply frame length wrong");

    a_write_quiet: assert property (@(posedge i_link_clk)
        disable iff (!i_arst_n)
        link_ff.state == vr_reg_pkg::LS_WDATA |-> !link_ff.sdio_oe ##1 !link_ff.sdio_oe)
        else $error("line driven during write");

endmodule

/* File: tb/vr_link_master.sv */
// Purpose: behavioural serial link master for the regulator register bank
// Assumes: data line is resolved outside with a pull-up; clock only runs in frames
// Notes: changes the line after the falling link edge, samples before the rising one
`timescale 1ns/1ps
module vr_link_master (
    output logic o_link_clk,
    output logic o_sdio_oe,
    output logic o_sdio_o,
    input wire logic i_sdio
);
    initial begin
        o_link_clk = 1'b0;
        o_sdio_oe = 1'b1;
        o_sdio_o = 1'b1;
    end

    // ************************************************************
    // one link clock, 48 ns
    // ************************************************************
    // master clocks link
    task automatic tick(input logic b, output logic s);
        o_sdio_o = b;
        #24;
        s = i_sdio;
        o_link_clk = 1'b1;
        #24;
        o_link_clk = 1'b0;
    endtask

    // ************************************************************
    // one frame: idle lead-in, start, header, then data or reply
    // ************************************************************
    task automatic frame(input logic [3:0] dom, input logic wr, input logic [7:0] idx,
            input logic [7:0] wdata, output logic got, output logic [7:0] rdata);
        logic [12:0] hdr;
        logic s;
        int n;
        hdr = {dom, wr, idx};
        got = 1'b0;
        rdata = 8'h00;
        #3;
        o_sdio_oe = 1'b1;
        repeat (3) tick(1'b1, s);
        tick(1'b0, s);
        for (int i = 12; i >= 0; i--) tick(hdr[i], s);
        if (wr) begin
            for (int i = 7; i >= 0; i--) tick(wdata[i], s);
        end else begin
            o_sdio_oe = 1'b0;
            n = 0;
            s = 1'b1;
            while (s !== 1'b0 && n < 10) begin
                tick(1'b1, s);
                n++;
            end
            got = (s === 1'b0);
            if (got) begin
                for (int i = 7; i >= 0; i--) begin
                    tick(1'b1, s);
                    rdata[i] = s;
                end
                tick(1'b1, s);
            end
            o_sdio_oe = 1'b1;
        end
        repeat (2) tick(1'b1, s);
    endtask
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the regulator serial register bank
// Assumes: 100 MHz core clock, link clock 48 ns inside frames only
// Notes: reads and writes go through the link master model
`timescale 1ns/1ps
module tb;
    // arbitrary identity values
    localparam logic [7:0] VEND = 8'h6b;
    localparam logic [7:0] PROD = 8'h2d;
    localparam logic [7:0] REV = 8'h03;
    localparam logic [7:0] DATE = 8'h47;
    localparam logic [3:0] SYSD = vr_reg_pkg::SYS_POWER_DOM;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_ce = 1'b1;
    logic link_clk, mst_oe, mst_o, sdio_o, sdio_oe, alert_o, alert_oe;
    wire logic sdio_line;
    wire logic alert_n;
    logic [7:0] pst = 8'h00, sst = 8'h00, tz = 8'h00, cur = 8'h00;
    logic [7:0] tmp = 8'h00, vin = 8'h00, pin = 8'h00, lim = 8'h77;
    logic [3:0] doms [5] = '{4'h0, 4'h1, 4'h2, 4'h3, SYSD};
    logic [7:0] gone [6] = '{8'h06, 8'h12, 8'h15, 8'h17, 8'h1a, 8'h21};
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    // pulled-up data line and open-drain attention line
    assign sdio_line = sdio_oe ? sdio_o : (mst_oe ? mst_o : 1'b1);
    assign alert_n = (alert_oe && !alert_o) ? 1'b0 : 1'b1;

    vr_serial_register_map #(.VENDOR_CODE(VEND), .PRODUCT_CODE(PROD),
            .SILICON_REVISION(REV), .MANUFACTURE_DATE(DATE)) vr_serial_register_map_inst (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_link_clk(link_clk),
        .i_sdio(sdio_line), .o_sdio_o(sdio_o), .o_sdio_oe(sdio_oe),
        .o_alert_o(alert_o), .o_alert_oe(alert_oe), .i_primary_status(pst),
        .i_secondary_status(sst), .i_thermal_zone(tz), .i_output_current_code(cur),
        .i_temperature_code(tmp), .i_supply_sense_code(vin), .i_supply_power_code(pin),
        .i_current_limit_program_pin_code(lim));

    vr_link_master vr_link_master_inst (
        .o_link_clk(link_clk), .o_sdio_oe(mst_oe), .o_sdio_o(mst_o), .i_sdio(sdio_line));

    always #5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            summarize();
        end
    end

    // ************************************************************
    // checking and access tasks
    // ************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [3:0] dom, input logic [7:0] idx, input logic here,
            input logic [7:0] exp);
        logic got;
        logic [7:0] d;
        vr_link_master_inst.frame(dom, 1'b0, idx, 8'h00, got, d);
        check({7'h00, got}, {7'h00, here});
        if (here) check(d, exp);
    endtask

    task automatic wr(input logic [3:0] dom, input logic [7:0] idx, input logic [7:0] v);
        logic got;
        logic [7:0] d;
        vr_link_master_inst.frame(dom, 1'b1, idx, v, got, d);
    endtask

    task automatic summarize();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (3) @(negedge i_clk);
        i_arst_n = 1'b1;
        repeat (3) @(negedge i_clk);
        lim = 8'h33;
        rd(4'h0, vr_reg_pkg::IDX_CURRENT_LIMIT, 1'b1, 8'h77);
        rd(4'h0, vr_reg_pkg::IDX_STATUS_SNAPSHOT, 1'b1, 8'h00);
        rd(4'h1, vr_reg_pkg::IDX_SECONDARY_STATUS, 1'b1, 8'h00);
        rd(4'h0, vr_reg_pkg::IDX_PRIMARY_STATUS, 1'b1, 8'h00);
        rd(4'h2, vr_reg_pkg::IDX_THERMAL_ZONE, 1'b1, 8'h00);
        check({7'h00, alert_n}, 8'h01);
        foreach (doms[k]) begin
            rd(doms[k], vr_reg_pkg::IDX_VENDOR_CODE, 1'b1, VEND);
            rd(doms[k], vr_reg_pkg::IDX_PRODUCT_CODE, 1'b1, PROD);
            rd(doms[k], vr_reg_pkg::IDX_SILICON_REVISION, 1'b1, REV);
            rd(doms[k], vr_reg_pkg::IDX_MANUFACTURE_DATE, 1'b1, DATE);
            rd(doms[k], vr_reg_pkg::IDX_PROTOCOL_VERSION, 1'b1, 8'h05);
            rd(doms[k], vr_reg_pkg::IDX_FEATURE_BITMAP, doms[k] != SYSD, 8'hd1);
            rd(doms[k], vr_reg_pkg::IDX_POWER_SCALING, doms[k] == SYSD, 8'hff);
        end
        foreach (gone[k]) rd(SYSD, gone[k], 1'b0, 8'h00);
        rd(4'h4, vr_reg_pkg::IDX_VENDOR_CODE, 1'b0, 8'h00);
        @(negedge i_clk);
        cur = 8'hff;
        tmp = 8'h64;
        vin = 8'h88;
        pin = 8'h4e;
        tz = 8'h05;
        sst = 8'h5c;
        rd(4'h1, vr_reg_pkg::IDX_OUTPUT_CURRENT, 1'b1, 8'hff);
        rd(4'h2, vr_reg_pkg::IDX_REG_TEMPERATURE, 1'b1, 8'h64);
        rd(4'h3, vr_reg_pkg::IDX_SUPPLY_VOLTAGE, 1'b1, 8'h88);
        rd(4'h0, vr_reg_pkg::IDX_SUPPLY_POWER, 1'b1, 8'h4e);
        rd(SYSD, vr_reg_pkg::IDX_SUPPLY_POWER, 1'b1, 8'h4e);
        rd(4'h1, vr_reg_pkg::IDX_THERMAL_ZONE, 1'b1, 8'h05);
        rd(SYSD, vr_reg_pkg::IDX_SECONDARY_STATUS, 1'b1, 8'h5c);
        @(negedge i_clk);
        sst = 8'h11;
        rd(SYSD, vr_reg_pkg::IDX_STATUS_SNAPSHOT, 1'b1, 8'h5c);
        rd(SYSD, vr_reg_pkg::IDX_SECONDARY_STATUS, 1'b1, 8'h11);
        rd(SYSD, vr_reg_pkg::IDX_STATUS_SNAPSHOT, 1'b1, 8'h11);
        wr(4'h0, vr_reg_pkg::IDX_CURRENT_LIMIT, 8'h99);
        wr(SYSD, vr_reg_pkg::IDX_STATUS_SNAPSHOT, 8'h99);
        wr(SYSD, vr_reg_pkg::IDX_POWER_SCALING, 8'h00);
        rd(4'h0, vr_reg_pkg::IDX_CURRENT_LIMIT, 1'b1, 8'h77);
        rd(SYSD, vr_reg_pkg::IDX_STATUS_SNAPSHOT, 1'b1, 8'h11);
        rd(SYSD, vr_reg_pkg::IDX_POWER_SCALING, 1'b1, 8'hff);
        @(negedge i_clk);
        pst = 8'h42;
        repeat (3) @(negedge i_clk);
        check({7'h00, alert_n}, 8'h00);
        rd(4'h0, vr_reg_pkg::IDX_PRIMARY_STATUS, 1'b1, 8'h42);
        repeat (3) @(negedge i_clk);
        check({7'h00, alert_n}, 8'h01);
        // clock enable low freezes the status capture
        i_ce = 1'b0;
        pst = 8'h24;
        repeat (5) @(negedge i_clk);
        check({7'h00, alert_n}, 8'h01);
        i_ce = 1'b1;
        repeat (3) @(negedge i_clk);
        check({7'h00, alert_n}, 8'h00);
        rd(4'h2, vr_reg_pkg::IDX_PRIMARY_STATUS, 1'b1, 8'h24);
        repeat (3) @(negedge i_clk);
        check({7'h00, alert_n}, 8'h01);
        summarize();
    end
endmodule
